// ### pkg/nic_irq_defs.svh
`ifndef NIC_IRQ_DEFS_SVH
`define NIC_IRQ_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define HOST_COMMAND_OFFSET 8'h00
`define INT_CAUSE_OFFSET 8'h04
`define CHANNEL_PARAMETER_AND_FAULT_STATUS_OFFSET 8'h08
`define LINK_STATUS_REGISTER_OFFSET 8'h0C
`define LINK_STATUS_MASK_OFFSET 8'h10
`define INDIRECT_ADDRESS_REGISTER_OFFSET 8'h14
`define INDIRECT_DATA_OFFSET 8'h18
`define TX_THRESHOLD_OFFSET 8'h1C
`define ADAPTER_CONFIG_OFFSET 8'h20
// ----------------------------------------
// Command and cause field positions
// ----------------------------------------
`define TYPE_LSB 2
`define TYPE_MSB 4
`define VEC_LSB 5
`define VEC_MSB 12
`define ACK_BIT 13
`define GO_TX_BIT 14
`define GO_RX_BIT 15
`define STOP_TX_BIT 16
`define STOP_RX_BIT 17
`define REQ_INT_BIT 18
`define THRESHOLD_LOAD_BIT 19
`define SOFT_RESET_BIT 20
`define ACK_COUNT_LSB 24
`define ACK_COUNT_MSB 31
`define ACK_MAX_PER_WRITE 7
// ----------------------------------------
// Link status flags, indirect address, config
// ----------------------------------------
`define PHY_IRQ_FLAG_BIT 0
`define HEARTBEAT_ERROR_FLAG_BIT 1
`define TX_HALTED_FLAG_BIT 2
`define RX_HALTED_FLAG_BIT 3
`define ADDR_INC_BIT 31
`define ADDR_STEP 16'h0004
`define PARITY_CHECK_ENABLE_BIT 8
`define PACE_LSB 0
`define PACE_MSB 7
`define PACE_RESET 8'h04
// ----------------------------------------
// Fault word layout and failure codes
// ----------------------------------------
`define FAULT_CHAN_LSB 21
`define FAULT_CHAN_MSB 28
`define FAULT_LIST_BIT 20
`define FAULT_RX_BIT 19
`define FAULT_READ_BIT 18
`define DATA_PARITY_FAULT 8'h01
`define ADDRESS_PARITY_FAULT 8'h02
`define MASTER_ABORT_FAULT 8'h03
`define TARGET_ABORT_FAULT 8'h04
`define LIST_FAULT 8'h05
`define OVER_ACKNOWLEDGE_FAULT 8'h06
`define COUNTER_OVERFLOW_FAULT 8'h07
`define MASTER_ABORT_CLOCKS 3'h6
`endif

// ### pkg/nic_irq_pkg.sv
`default_nettype none
package nic_irq_pkg;
  typedef enum logic [2:0] {
    TYPE_NONE = 3'h0,
    TYPE_TX_EOF = 3'h1,
    TYPE_STATS = 3'h2,
    TYPE_RX_EOF = 3'h3,
    TYPE_DUMMY = 3'h4,
    TYPE_TX_EOC = 3'h5,
    TYPE_STATUS = 3'h6,
    TYPE_RX_EOC = 3'h7
  } int_type_e;

  typedef struct packed {
    logic [9:0] tx_eof_cnt;
    logic [9:0] rx_eof_cnt;
    logic tx_eoc;
    logic rx_eoc;
    logic stat_pend;
    logic dummy_pend;
    logic [3:0] link_status_register;
    logic [3:0] link_status_mask;
    logic [7:0] thresh;
    logic tx_run;
    logic rx_run;
    logic chk_active;
    logic [31:0] fault;
    logic [31:0] list_addr;
    logic [15:0] indirect_address_register;
    logic addr_inc;
    logic parity_check_enable;
    logic [7:0] pace_load;
    logic [7:0] pace_cnt;
    logic irq_en;
    logic rr_rx;
    logic [2:0] ma_cnt;
    logic master_abort;
    logic [31:0] prdata;
    logic pslverr;
  } state_s;
endpackage : nic_irq_pkg
`default_nettype wire

// ### hw/nic_irq_ctrl.sv
`include "nic_irq_defs.svh"
`default_nettype none
module nic_irq_ctrl
  import nic_irq_pkg::*;
#(
  parameter int ACK_MAX = `ACK_MAX_PER_WRITE
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_eof_evt,
  input wire logic tx_eoc_evt,
  input wire logic rx_eof_evt,
  input wire logic rx_eoc_evt,
  input wire logic stat_half_evt,
  input wire logic phy_irq_evt,
  input wire logic heartbeat_evt,
  input wire logic data_parity_evt,
  input wire logic address_parity_evt,
  input wire logic target_abort_evt,
  input wire logic list_fault_evt,
  input wire logic master_start,
  input wire logic target_claim_signal,
  input wire logic [7:0] active_channel,
  input wire logic op_list,
  input wire logic op_rx,
  input wire logic op_read,
  input wire logic [31:0] stat_rdata,
  output logic stat_read,
  output logic [15:0] indirect_addr,
  output logic [31:0] list_addr,
  output logic irq,
  output logic tx_run,
  output logic rx_run,
  output logic off_network,
  output logic master_abort
);
  initial
  begin
    if (ACK_MAX < 1 || ACK_MAX > 255)
      $error("ACK_MAX out of range");
  end

  localparam state_s STATE_RST = '{pace_load: `PACE_RESET, irq_en: 1'b1, default: '0};

  state_s s;
  state_s next_s;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic cmd_wr;
  logic soft_rst_wr;
  logic [2:0] wtype;
  logic [7:0] wcount;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign mapped = (paddr <= `ADAPTER_CONFIG_OFFSET) && (paddr[1:0] == 2'h0);
  assign cmd_wr = wr && paddr == `HOST_COMMAND_OFFSET;
  assign soft_rst_wr = cmd_wr && pwdata[`SOFT_RESET_BIT];
  assign wtype = pwdata[`TYPE_MSB:`TYPE_LSB];
  assign wcount = pwdata[`ACK_COUNT_MSB:`ACK_COUNT_LSB];

  // ----------------------------------------
  // Cause priority
  // ----------------------------------------
  logic status_pend;
  logic tx_eof_pend;
  logic rx_pend;
  logic tx_pend;
  logic src_active;
  int_type_e cause_type;
  logic [7:0] cause_vec;
  logic [31:0] cause_word;
  assign status_pend = |(s.link_status_register & ~s.link_status_mask);
  assign tx_eof_pend = s.thresh != 8'h00 && s.tx_eof_cnt >= {2'h0, s.thresh};
  assign rx_pend = s.rx_eof_cnt != 10'h000 || s.rx_eoc;
  assign tx_pend = tx_eof_pend || s.tx_eoc;
  assign src_active = s.chk_active || status_pend || s.stat_pend || s.dummy_pend || rx_pend || tx_pend;

  always_comb
  begin
    cause_vec = 8'h00;
    if (s.chk_active)
    begin
      cause_type = TYPE_STATUS;
      cause_vec = s.fault[7:0];
    end
    else if (status_pend)
      cause_type = TYPE_STATUS;
    else if (s.stat_pend)
      cause_type = TYPE_STATS;
    else if (s.dummy_pend)
      cause_type = TYPE_DUMMY;
    else if (rx_pend && (!tx_pend || s.rr_rx))
      cause_type = s.rx_eof_cnt != 10'h000 ? TYPE_RX_EOF : TYPE_RX_EOC;
    else if (tx_pend)
      cause_type = tx_eof_pend ? TYPE_TX_EOF : TYPE_TX_EOC;
    else
      cause_type = TYPE_NONE;
  end

  assign cause_word = {19'h0, cause_vec, cause_type, 2'b00};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [9:0] tx_cnt;
    logic [9:0] rx_cnt;
    logic ack_err;
    logic ovf_err;
    logic ovf_rx;
    logic ovf_eoc;
    logic [7:0] code;
    logic [31:0] fword;
    tx_cnt = s.tx_eof_cnt;
    rx_cnt = s.rx_eof_cnt;
    ack_err = 1'b0;
    ovf_err = 1'b0;
    ovf_rx = 1'b0;
    ovf_eoc = 1'b0;
    code = 8'h00;
    fword = 32'h0000_0000;
    next_s = s;
    next_s.master_abort = 1'b0;
    next_s.pslverr = 1'b0;

    // Read data staged in setup so the access phase answers from a flop
    if (setup)
    begin
      next_s.pslverr = !mapped;
      unique case (paddr)
        `HOST_COMMAND_OFFSET: next_s.prdata = 32'h0000_0000;
        `INT_CAUSE_OFFSET: next_s.prdata = cause_word;
        `CHANNEL_PARAMETER_AND_FAULT_STATUS_OFFSET: next_s.prdata = s.chk_active ? s.fault : s.list_addr;
        `LINK_STATUS_REGISTER_OFFSET: next_s.prdata = {28'h0, s.link_status_register};
        `LINK_STATUS_MASK_OFFSET: next_s.prdata = {28'h0, s.link_status_mask};
        `INDIRECT_ADDRESS_REGISTER_OFFSET: next_s.prdata = {s.addr_inc, 15'h0, s.indirect_address_register};
        `INDIRECT_DATA_OFFSET: next_s.prdata = stat_rdata;
        `TX_THRESHOLD_OFFSET: next_s.prdata = {24'h0, s.thresh};
        `ADAPTER_CONFIG_OFFSET: next_s.prdata = {23'h0, s.parity_check_enable, s.pace_load};
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end

    // Pacing timer
    if (s.pace_cnt != 8'h00)
      next_s.pace_cnt = s.pace_cnt - 8'h01;

    // Master abort watchdog runs even during a check, but entering a check zeroes ma_cnt and drops a bus cycle in flight
    if (s.ma_cnt != 3'h0)
    begin
      if (target_claim_signal)
        next_s.ma_cnt = 3'h0;
      else
      begin
        next_s.ma_cnt = s.ma_cnt - 3'h1;
        next_s.master_abort = s.ma_cnt == 3'h1;
      end
    end
    else if (master_start)
      next_s.ma_cnt = `MASTER_ABORT_CLOCKS;

    if (rd && paddr == `INDIRECT_DATA_OFFSET && s.addr_inc)
      next_s.indirect_address_register = s.indirect_address_register + `ADDR_STEP;

    if (!s.chk_active)
    begin
      // Register writes
      if (wr)
      begin
        unique case (paddr)
          `INT_CAUSE_OFFSET: next_s.irq_en = 1'b0;
          `CHANNEL_PARAMETER_AND_FAULT_STATUS_OFFSET: next_s.list_addr = pwdata;
          `LINK_STATUS_REGISTER_OFFSET: next_s.link_status_register = s.link_status_register & ~pwdata[3:0];
          `LINK_STATUS_MASK_OFFSET: next_s.link_status_mask = pwdata[3:0];
          `INDIRECT_ADDRESS_REGISTER_OFFSET:
          begin
            next_s.indirect_address_register = pwdata[15:0];
            next_s.addr_inc = pwdata[`ADDR_INC_BIT];
          end
          `ADAPTER_CONFIG_OFFSET:
          begin
            next_s.parity_check_enable = pwdata[`PARITY_CHECK_ENABLE_BIT];
            next_s.pace_load = pwdata[`PACE_MSB:`PACE_LSB];
          end
          default: next_s.irq_en = s.irq_en;
        endcase
      end

      // Acknowledge first, so an ack and a restart may share one write
      if (cmd_wr && pwdata[`ACK_BIT])
      begin
        next_s.pace_cnt = s.pace_load;
        next_s.irq_en = 1'b1;
        if (wcount > 8'(ACK_MAX))
          ack_err = 1'b1;
        unique case (wtype)
          TYPE_TX_EOF:
          begin
            if ({2'h0, wcount} > tx_cnt)
              ack_err = 1'b1;
            else
              tx_cnt = tx_cnt - {2'h0, wcount};
            next_s.rr_rx = 1'b1;
          end
          TYPE_RX_EOF:
          begin
            if ({2'h0, wcount} > rx_cnt)
              ack_err = 1'b1;
            else
              rx_cnt = rx_cnt - {2'h0, wcount};
            next_s.rr_rx = 1'b0;
          end
          TYPE_TX_EOC:
          begin
            ack_err = ack_err || !s.tx_eoc;
            next_s.tx_eoc = 1'b0;
            next_s.rr_rx = 1'b1;
          end
          TYPE_RX_EOC:
          begin
            ack_err = ack_err || !s.rx_eoc;
            next_s.rx_eoc = 1'b0;
            next_s.rr_rx = 1'b0;
          end
          TYPE_STATS: next_s.stat_pend = 1'b0;
          TYPE_DUMMY: next_s.dummy_pend = 1'b0;
          default: next_s.rr_rx = s.rr_rx;
        endcase
      end

      if (cmd_wr)
      begin
        if (pwdata[`GO_TX_BIT])
        begin
          if (next_s.tx_eoc)
            ovf_err = 1'b1;
          else
            next_s.tx_run = 1'b1;
        end
        if (pwdata[`GO_RX_BIT])
        begin
          if (next_s.rx_eoc)
          begin
            ovf_err = 1'b1;
            ovf_rx = 1'b1;
          end
          else
            next_s.rx_run = 1'b1;
        end
        ovf_eoc = ovf_err;
        if (pwdata[`STOP_TX_BIT])
        begin
          next_s.tx_run = 1'b0;
          next_s.link_status_register[`TX_HALTED_FLAG_BIT] = 1'b1;
        end
        if (pwdata[`STOP_RX_BIT])
        begin
          next_s.rx_run = 1'b0;
          next_s.link_status_register[`RX_HALTED_FLAG_BIT] = 1'b1;
        end
        if (pwdata[`REQ_INT_BIT])
          next_s.dummy_pend = 1'b1;
        if (pwdata[`THRESHOLD_LOAD_BIT])
        begin
          next_s.thresh = wcount;
          if (wcount == 8'h00)
            next_s.tx_eoc = 1'b1;
        end
      end

      // Events, applied after clears so a coincident event is kept
      if (tx_eof_evt && s.thresh != 8'h00)
      begin
        if (tx_cnt == 10'h3FF)
          ovf_err = 1'b1;
        else
          tx_cnt = tx_cnt + 10'h001;
      end
      if (rx_eof_evt)
      begin
        if (rx_cnt == 10'h3FF)
        begin
          ovf_err = 1'b1;
          ovf_rx = 1'b1;
        end
        else
          rx_cnt = rx_cnt + 10'h001;
      end
      next_s.tx_eof_cnt = tx_cnt;
      next_s.rx_eof_cnt = rx_cnt;
      if (tx_eoc_evt)
      begin
        next_s.tx_eoc = 1'b1;
        next_s.tx_run = 1'b0;
      end
      if (rx_eoc_evt)
      begin
        next_s.rx_eoc = 1'b1;
        next_s.rx_run = 1'b0;
      end
      if (stat_half_evt)
        next_s.stat_pend = 1'b1;
      if (phy_irq_evt)
        next_s.link_status_register[`PHY_IRQ_FLAG_BIT] = 1'b1;
      if (heartbeat_evt)
        next_s.link_status_register[`HEARTBEAT_ERROR_FLAG_BIT] = 1'b1;

      // Fault capture, lowest code wins
      if (data_parity_evt && s.parity_check_enable)
        code = `DATA_PARITY_FAULT;
      else if (address_parity_evt && s.parity_check_enable)
        code = `ADDRESS_PARITY_FAULT;
      else if (s.master_abort)
        code = `MASTER_ABORT_FAULT;
      else if (target_abort_evt)
        code = `TARGET_ABORT_FAULT;
      else if (list_fault_evt)
        code = `LIST_FAULT;
      else if (ack_err)
        code = `OVER_ACKNOWLEDGE_FAULT;
      else if (ovf_err)
        code = `COUNTER_OVERFLOW_FAULT;
      fword[7:0] = code;
      if (code == `DATA_PARITY_FAULT || code == `MASTER_ABORT_FAULT || code == `TARGET_ABORT_FAULT)
      begin
        fword[`FAULT_CHAN_MSB:`FAULT_CHAN_LSB] = active_channel;
        fword[`FAULT_LIST_BIT] = op_list;
        fword[`FAULT_RX_BIT] = op_rx;
        fword[`FAULT_READ_BIT] = op_read;
      end
      else if (code == `LIST_FAULT)
      begin
        fword[`FAULT_CHAN_MSB:`FAULT_CHAN_LSB] = active_channel;
        fword[`FAULT_RX_BIT] = op_rx;
      end
      else if (code == `OVER_ACKNOWLEDGE_FAULT)
      begin
        fword[`FAULT_LIST_BIT] = wtype == TYPE_TX_EOC || wtype == TYPE_RX_EOC;
        fword[`FAULT_RX_BIT] = wtype == TYPE_RX_EOF || wtype == TYPE_RX_EOC;
      end
      else if (code == `COUNTER_OVERFLOW_FAULT)
      begin
        fword[`FAULT_LIST_BIT] = ovf_eoc;
        fword[`FAULT_RX_BIT] = ovf_rx;
      end

      // Entering a check wipes every other source and leaves the wire
      if (code != 8'h00)
      begin
        next_s = STATE_RST;
        next_s.chk_active = 1'b1;
        next_s.fault = fword;
        next_s.prdata = s.prdata;
        next_s.list_addr = s.list_addr;
        next_s.pace_cnt = 8'h00;
        next_s.pace_load = s.pace_load;
        next_s.parity_check_enable = s.parity_check_enable;
        next_s.ma_cnt = next_s.ma_cnt;
      end
    end

    // Only the reset bit leaves a check; an ack does not
    if (soft_rst_wr)
      next_s = STATE_RST;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= STATE_RST;
    else
      s <= next_s;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready = 1'b1;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr && psel && penable;
  assign stat_read = rd && paddr == `INDIRECT_DATA_OFFSET;
  assign indirect_addr = s.indirect_address_register;
  assign list_addr = s.list_addr;
  assign irq = s.irq_en && s.pace_cnt == 8'h00 && src_active;
  assign tx_run = s.tx_run;
  assign rx_run = s.rx_run;
  assign off_network = s.chk_active;
  assign master_abort = s.master_abort;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_idle_type_zero: assert property (!src_active |-> cause_type == TYPE_NONE)
    else $error("cause type nonzero while idle");
  chk_zero_thr_quiet: assert property (s.thresh == 8'h00 |-> cause_type != TYPE_TX_EOF)
    else $error("tx frame cause with zero threshold");
  chk_eoc_halts_tx: assert property (tx_eoc_evt && !s.chk_active && !soft_rst_wr |=> !s.tx_run && (s.tx_eoc || s.chk_active))
    else $error("tx not halted after end of channel");
  chk_dummy_raised: assert property (cmd_wr && pwdata[`REQ_INT_BIT] && !s.chk_active && !soft_rst_wr
    ##1 !s.chk_active |-> s.dummy_pend)
    else $error("dummy request lost");
  chk_addr_autoinc: assert property (rd && paddr == `INDIRECT_DATA_OFFSET && s.addr_inc && !soft_rst_wr
    |=> s.indirect_address_register == $past(s.indirect_address_register) + `ADDR_STEP)
    else $error("indirect address not advanced");
  chk_check_sticky: assert property (s.chk_active && !soft_rst_wr |=> s.chk_active && $stable(s.fault))
    else $error("adapter check left without reset");
  chk_fault_layout: assert property (s.chk_active |-> s.fault[31:29] == 3'h0 && s.fault[17:8] == 10'h000
    && s.fault[7:0] != 8'h00 && cause_type == TYPE_STATUS)
    else $error("fault word malformed");
  chk_abort_six: assert property ((master_start && s.ma_cnt == 3'h0) ##1 (!target_claim_signal && !soft_rst_wr) [*6]
    |=> s.master_abort)
    else $error("master abort not raised after six clocks");
  chk_go_overflow: assert property (cmd_wr && pwdata[`GO_TX_BIT] && s.tx_eoc && !soft_rst_wr && !s.chk_active
    && !(pwdata[`ACK_BIT] && wtype == TYPE_TX_EOC) |=> s.chk_active && s.fault[7:0] != 8'h00)
    else $error("start over pending end of channel not trapped");
  chk_pacing_hold: assert property (s.pace_cnt != 8'h00 |-> !irq)
    else $error("interrupt during pacing interval");
  chk_check_clears: assert property ($rose(s.chk_active) |-> s.tx_eof_cnt == 10'h000 && !s.stat_pend
    && s.link_status_register == 4'h0)
    else $error("sources survive adapter check");

  cov_adapter_check: cover property ($rose(s.chk_active));
  cov_tx_frame_irq: cover property (irq && cause_type == TYPE_TX_EOF);
  cov_status_irq: cover property (irq && cause_type == TYPE_STATUS && !s.chk_active);
  cov_master_abort: cover property (s.master_abort);
endmodule : nic_irq_ctrl
`default_nettype wire

// ### tb/claim_model.sv
`default_nettype none
// ----------------------------------------
// Far side: bus target claim and statistics
// ----------------------------------------
module claim_model
  import nic_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_start,
  input wire logic claim_en,
  input wire logic [15:0] indirect_addr,
  output logic target_claim_signal,
  output logic [31:0] stat_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= 3'h0;
    else if (master_start)
      cnt <= 3'h1;
    else if (cnt != 3'h0 && cnt != 3'h7)
      cnt <= cnt + 3'h1;
  end
  // Claim only briefly, then release as a real target would
  assign target_claim_signal = claim_en && cnt >= 3'h3 && cnt <= 3'h5;
  assign stat_rdata = {16'hC3C3, indirect_addr};
endmodule : claim_model
`default_nettype wire

// ### tb/tb_nic_irq_ctrl.sv
`default_nettype none
module tb_nic_irq_ctrl;
  import nic_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, serr, ms = 0, claim_en = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, stat_rdata;
  logic [10:0] ev = 11'h0;
  logic [15:0] indirect_addr;
  logic claim, off_network, irq, tx_run, rx_run;
  logic [31:0] laddr;
  int num_errors = 0, n_checks = 0;
  always #25 clk = ~clk;
  nic_irq_ctrl u_nic_irq_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_eof_evt(ev[0]), .rx_eof_evt(ev[1]), .rx_eoc_evt(ev[2]), .stat_half_evt(ev[3]),
    .phy_irq_evt(ev[4]), .tx_eoc_evt(ev[5]), .heartbeat_evt(ev[6]), .data_parity_evt(ev[7]),
    .address_parity_evt(ev[8]), .target_abort_evt(ev[9]), .list_fault_evt(ev[10]),
    .master_start(ms), .target_claim_signal(claim), .active_channel(8'h05), .op_list(1'b1),
    .op_rx(1'b0), .op_read(1'b1), .stat_rdata(stat_rdata), .stat_read(), .indirect_addr(indirect_addr),
    .list_addr(laddr), .irq(irq), .tx_run(tx_run), .rx_run(rx_run), .off_network(off_network), .master_abort());
  claim_model u_claim_model (.clk(clk), .rst_n(rst_n), .master_start(ms), .claim_en(claim_en),
    .indirect_addr(indirect_addr), .target_claim_signal(claim), .stat_rdata(stat_rdata));
  // ----------------------------------------
  // Bus master and checking
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle cycle so the next setup never lands in this time step
    @(posedge clk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk) ev[i] <= 1'b0;
    @(posedge clk);
  endtask : pulse
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_map;
    rchk(8'h04, 32'h0);
    rchk(8'h20, 32'h00000004);
    rchk(8'h24, 32'h0);
    chk({31'h0, serr}, 32'h1);
  endtask : t_reset_map
  task automatic t_list_events;
    logic [31:0] exp[5] = '{32'h04, 32'h0C, 32'h1C, 32'h08, 32'h14};
    apb(1'b1, 8'h00, 32'h0108C000);
    chk({30'h0, tx_run, rx_run}, 32'h3);
    for (int i = 0; i < 5; i++)
    begin
      // Last slot is transmit end-of-channel, wired to event bit 5
      pulse(i < 4 ? i : 5);
      chk({31'h0, irq}, 32'h1);
      rchk(8'h04, exp[i]);
      apb(1'b1, 8'h00, 32'h01002000 | exp[i]);
      rchk(8'h04, 32'h0);
    end
    chk({30'h0, tx_run, rx_run}, 32'h0);
    apb(1'b1, 8'h00, 32'h00080000);
    pulse(0);
    rchk(8'h04, 32'h14);
    apb(1'b1, 8'h00, 32'h00002014);
    apb(1'b1, 8'h00, 32'h00040000);
    rchk(8'h04, 32'h10);
    apb(1'b1, 8'h00, 32'h00002010);
    rchk(8'h04, 32'h0);
  endtask : t_list_events
  task automatic t_status;
    apb(1'b1, 8'h00, 32'h00010000);
    rchk(8'h0C, 32'h4);
    rchk(8'h04, 32'h18);
    apb(1'b1, 8'h0C, 32'h4);
    rchk(8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    pulse(4);
    rchk(8'h04, 32'h0);
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h08, 32'h12345678);
    rchk(8'h08, 32'h12345678);
    chk(laddr, 32'h12345678);
    apb(1'b1, 8'h14, 32'h80000010);
    rchk(8'h18, 32'hC3C30010);
    rchk(8'h18, 32'hC3C30014);
  endtask : t_status
  task automatic t_faults;
    apb(1'b1, 8'h00, 32'h01002004);
    rchk(8'h08, 32'h00000006);
    rchk(8'h04, 32'h000000D8);
    apb(1'b1, 8'h00, 32'h00100000);
    ms <= 1'b1;
    @(posedge clk) ms <= 1'b0;
    repeat (12) @(posedge clk);
    chk({31'h0, off_network}, 32'h0);
    claim_en <= 1'b0;
    ms <= 1'b1;
    @(posedge clk) ms <= 1'b0;
    for (int k = 0; k < 12 && off_network !== 1'b1; k++) @(posedge clk);
    chk({31'h0, off_network}, 32'h1);
    rchk(8'h08, 32'h00B40003);
    apb(1'b1, 8'h00, 32'h01002078);
    rchk(8'h04, 32'h00000078);
    apb(1'b1, 8'h00, 32'h00100000);
    rchk(8'h04, 32'h0);
    chk({31'h0, off_network}, 32'h0);
    pulse(10);
    rchk(8'h08, 32'h00A00005);
    apb(1'b1, 8'h00, 32'h00100000);
    apb(1'b1, 8'h00, 32'h00080000);
    apb(1'b1, 8'h00, 32'h00004000);
    rchk(8'h08, 32'h00100007);
    apb(1'b1, 8'h00, 32'h00100000);
    chk({31'h0, off_network}, 32'h0);
  endtask : t_faults
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_map();
    t_list_events();
    t_status();
    t_faults();
    print_verdict();
  end
endmodule : tb_nic_irq_ctrl
`default_nettype wire
